// File: pkg/dcrl_pkg.sv
// constants and types of the channel context-reload block
package dcrl_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DCRL_DW = 16;
  localparam int DCRL_AW = 4;
  localparam int DCRL_CFG_WORDS = 3;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [3:0] DCRL_OFS_CTRL = 4'h0;
  localparam logic [3:0] DCRL_OFS_CFG_SRC = 4'h2;
  localparam logic [3:0] DCRL_OFS_CFG_DST = 4'h4;
  localparam logic [3:0] DCRL_OFS_CFG_CNT = 4'h6;
  localparam logic [3:0] DCRL_OFS_WRK_SRC = 4'h8;
  localparam logic [3:0] DCRL_OFS_WRK_DST = 4'hA;
  localparam logic [3:0] DCRL_OFS_WRK_CNT = 4'hC;
  localparam logic [3:0] DCRL_OFS_STATUS = 4'hE;

  // ----------------------------------------
  // configuration word indices
  // ----------------------------------------
  localparam logic [1:0] DCRL_IDX_SRC = 2'h0;
  localparam logic [1:0] DCRL_IDX_DST = 2'h1;
  localparam logic [1:0] DCRL_IDX_CNT = 2'h2;
  localparam logic [1:0] DCRL_IDX_NONE = 2'h3;

  // ----------------------------------------
  // channel_control fields
  // ----------------------------------------
  localparam int DCRL_BIT_DONE = 11;
  localparam int DCRL_BIT_RSVD = 10;
  localparam int DCRL_BIT_NOWAIT = 9;
  localparam int DCRL_BIT_AUTO = 8;
  localparam int DCRL_BIT_EN = 7;
  localparam int DCRL_BIT_PRIO = 6;
  localparam logic [15:0] DCRL_CTRL_WMASK = 16'h0BC0;
  localparam logic [15:0] DCRL_CTRL_RST = 16'h0000;
  localparam logic [15:0] DCRL_WORD_RST = 16'h0000;

  // ----------------------------------------
  // reload sequencer states, gray along idle-run-end-wait
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCRL_ST_IDLE = 2'h0,
    DCRL_ST_RUN = 2'h1,
    DCRL_ST_END = 2'h3,
    DCRL_ST_WAIT = 2'h2
  } dcrl_state_t;

endpackage

// File: pkg/dcrl_ctx_if.sv
// context bundle between configuration set, working set and sequencer
`timescale 1ns/10ps
interface dcrl_ctx_if #(parameter int DW = 16);
  logic [DW-1:0] cfg_src;
  logic [DW-1:0] cfg_dst;
  logic [DW-1:0] cfg_cnt;
  logic load;
  logic step;
  logic [DW-1:0] wrk_src;
  logic [DW-1:0] wrk_dst;
  logic [DW-1:0] wrk_cnt;
  logic last;

  // configuration set drives the programmed context
  modport cfg_side (output cfg_src, output cfg_dst, output cfg_cnt);
  // working set copies on load and advances on step
  modport wrk_side (input cfg_src, input cfg_dst, input cfg_cnt,
                    input load, input step,
                    output wrk_src, output wrk_dst, output wrk_cnt,
                    output last);
  // sequencer watches both sets and commands the copy
  modport ctl_side (input cfg_src, input cfg_dst, input cfg_cnt,
                    output load, output step,
                    input wrk_src, input wrk_dst, input wrk_cnt,
                    input last);
endinterface

// File: rtl/dcrl_cfg_set.sv
// programmable configuration (shadow) register set of one channel
`timescale 1ns/10ps
module dcrl_cfg_set
  import dcrl_pkg::*;
#(
  parameter int DW = DCRL_DW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register writes
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic [DW-1:0] cfg_wdata,
  // context out
  dcrl_ctx_if.cfg_side ctx
);

  logic [DW-1:0] cfg_word [DCRL_CFG_WORDS];

  // ----------------------------------------
  // one word per configuration field
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DCRL_CFG_WORDS; gi++) begin : g_word
      // writes land here only, never in the working set
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_word[gi] <= DW'(DCRL_WORD_RST);
        end else if (cfg_wr && (cfg_sel == 2'(gi))) begin
          cfg_word[gi] <= cfg_wdata;
        end
      end
    end
  endgenerate

  // fields out to the copy path
  assign ctx.cfg_src = cfg_word[DCRL_IDX_SRC];
  assign ctx.cfg_dst = cfg_word[DCRL_IDX_DST];
  assign ctx.cfg_cnt = cfg_word[DCRL_IDX_CNT];

endmodule

// File: rtl/dcrl_work_set.sv
// working register set that governs the running block
`timescale 1ns/10ps
module dcrl_work_set
  import dcrl_pkg::*;
#(
  parameter int DW = DCRL_DW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // context in and out
  dcrl_ctx_if.wrk_side ctx
);

  logic [DW-1:0] src;
  logic [DW-1:0] dst;
  logic [DW-1:0] cnt;
  logic [DW-1:0] next_src;
  logic [DW-1:0] next_dst;
  logic [DW-1:0] next_cnt;

  // ----------------------------------------
  // copy on load, advance one element on step
  // ----------------------------------------
  assign next_src = ctx.load ? ctx.cfg_src :
                    ctx.step ? src + DW'(1) : src;
  assign next_dst = ctx.load ? ctx.cfg_dst :
                    ctx.step ? dst + DW'(1) : dst;
  assign next_cnt = ctx.load ? ctx.cfg_cnt :
                    ctx.step ? cnt - DW'(1) : cnt;

  // working registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src <= DW'(DCRL_WORD_RST);
      dst <= DW'(DCRL_WORD_RST);
      cnt <= DW'(DCRL_WORD_RST);
    end else begin
      src <= next_src;
      dst <= next_dst;
      cnt <= next_cnt;
    end
  end

  // a count of zero or one ends the block on this element
  assign ctx.last = (cnt <= DW'(1));
  assign ctx.wrk_src = src;
  assign ctx.wrk_dst = dst;
  assign ctx.wrk_cnt = cnt;

endmodule

// File: rtl/dcrl_top.sv
// channel context-reload controller: registers, sequencer, two sets
//
// Contract
// - keep separate configuration and working register sets
// - configuration writes never touch the running working set
// - at block end with auto reload, copy and restart
// - hardware clears config_done_flag after each reload copy
// - config_done_flag is control bit 11
// - without nowait, reload waits for flag; else immediate
// - auto reload on restarts; off stops at block end
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module dcrl_top
  import dcrl_pkg::*;
#(
  parameter int DW = DCRL_DW,
  parameter int AW = DCRL_AW
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // transfer side
  output logic xfer_step,
  output logic [DW-1:0] xfer_src,
  output logic [DW-1:0] xfer_dst,
  output logic chan_busy,
  output logic block_done,
  output logic reload_done
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------

  // maps an address onto a configuration word index
  function automatic logic [1:0] cfg_index(input logic [AW-1:0] a);
    logic [1:0] idx;
    idx = DCRL_IDX_NONE;
    if (a == AW'(DCRL_OFS_CFG_SRC)) begin
      idx = DCRL_IDX_SRC;
    end else if (a == AW'(DCRL_OFS_CFG_DST)) begin
      idx = DCRL_IDX_DST;
    end else if (a == AW'(DCRL_OFS_CFG_CNT)) begin
      idx = DCRL_IDX_CNT;
    end
    return idx;
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  // asynchronous assert, two-flop release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // the two register sets
  // ----------------------------------------
  dcrl_ctx_if #(.DW(DW)) ctx ();

  logic cfg_wr;
  logic [1:0] cfg_sel;
  logic [1:0] rd_sel;

  // configuration writes go to the shadow set only
  assign cfg_sel = cfg_index(reg_addr);
  assign cfg_wr = reg_wr && (cfg_sel != DCRL_IDX_NONE);

  // shadow set, programmable while a block runs
  dcrl_cfg_set #(.DW(DW)) u_cfg (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .cfg_wr(cfg_wr),
    .cfg_sel(cfg_sel),
    .cfg_wdata(reg_wdata),
    .ctx(ctx.cfg_side)
  );

  // working set, changed only by the sequencer
  dcrl_work_set #(.DW(DW)) u_wrk (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .ctx(ctx.wrk_side)
  );

  // ----------------------------------------
  // channel_control register
  // ----------------------------------------
  logic [DW-1:0] ctrl;
  logic [DW-1:0] next_ctrl;
  logic [DW-1:0] ctrl_base;
  logic [DW-1:0] hw_clr_mask;
  logic ctrl_wr;
  logic clr_flag;
  logic clr_en;
  logic ctl_en;
  logic ctl_auto;
  logic ctl_nowait;
  logic ctl_flag;

  // writable bits only; reserved bit 10 and the rest hold zero
  assign ctrl_wr = reg_wr && (reg_addr == AW'(DCRL_OFS_CTRL));
  assign ctrl_base = ctrl_wr ? (reg_wdata & DW'(DCRL_CTRL_WMASK)) : ctrl;

  // hardware clears applied after the host value, so they win
  assign hw_clr_mask = (DW'(clr_flag) << DCRL_BIT_DONE) |
                       (DW'(clr_en) << DCRL_BIT_EN);
  assign next_ctrl = ctrl_base & ~hw_clr_mask;

  // control register state
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl <= DW'(DCRL_CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // field taps
  assign ctl_flag = ctrl[DCRL_BIT_DONE];
  assign ctl_nowait = ctrl[DCRL_BIT_NOWAIT];
  assign ctl_auto = ctrl[DCRL_BIT_AUTO];
  assign ctl_en = ctrl[DCRL_BIT_EN];

  // ----------------------------------------
  // reload sequencer
  // ----------------------------------------
  dcrl_state_t state;
  dcrl_state_t next_state;
  logic load;
  logic step;
  logic may_reload;

  // nowait reloads at once, otherwise the flag must be set
  assign may_reload = ctl_nowait || ctl_flag;

  // next state and copy commands
  always_comb begin
    next_state = state;
    load = 1'b0;
    step = 1'b0;
    clr_flag = 1'b0;
    clr_en = 1'b0;
    case (state)
      DCRL_ST_IDLE: begin
        // first block takes the programmed context
        if (ctl_en) begin
          load = 1'b1;
          next_state = DCRL_ST_RUN;
        end
      end
      DCRL_ST_RUN: begin
        // one element per cycle until the last one
        if (!ctl_en) begin
          next_state = DCRL_ST_IDLE;
        end else begin
          step = 1'b1;
          if (ctx.last) begin
            next_state = DCRL_ST_END;
          end
        end
      end
      DCRL_ST_END: begin
        // block finished: stop, reload or wait for the host
        if (!ctl_en) begin
          next_state = DCRL_ST_IDLE;
        end else if (!ctl_auto) begin
          clr_en = 1'b1;
          next_state = DCRL_ST_IDLE;
        end else if (may_reload) begin
          load = 1'b1;
          clr_flag = 1'b1;
          next_state = DCRL_ST_RUN;
        end else begin
          next_state = DCRL_ST_WAIT;
        end
      end
      DCRL_ST_WAIT: begin
        // held until the host marks programming complete
        if (!ctl_en) begin
          next_state = DCRL_ST_IDLE;
        end else if (!ctl_auto) begin
          clr_en = 1'b1;
          next_state = DCRL_ST_IDLE;
        end else if (may_reload) begin
          load = 1'b1;
          clr_flag = 1'b1;
          next_state = DCRL_ST_RUN;
        end
      end
      default: begin
        next_state = DCRL_ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= DCRL_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // commands to the working set
  assign ctx.load = load;
  assign ctx.step = step;

  // ----------------------------------------
  // event pulses
  // ----------------------------------------
  logic next_block_done;
  logic next_reload_done;

  // block end seen and reload copy taken
  assign next_block_done = step && ctx.last;
  assign next_reload_done = load && clr_flag;

  // one-cycle pulses, a cycle after their cause
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      block_done <= 1'b0;
      reload_done <= 1'b0;
    end else begin
      block_done <= next_block_done;
      reload_done <= next_reload_done;
    end
  end

  // transfer side outputs
  assign xfer_step = step;
  assign xfer_src = ctx.wrk_src;
  assign xfer_dst = ctx.wrk_dst;
  assign chan_busy = (state != DCRL_ST_IDLE);

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  logic [DW-1:0] status_word;
  logic [DW-1:0] cfg_rd_word;
  logic [DW-1:0] rd_value;
  logic [DW-1:0] next_rdata;

  // status: state code, busy, waiting for the host
  assign status_word = {{(DW-4){1'b0}},
                        (state == DCRL_ST_WAIT),
                        chan_busy,
                        state};

  // shadow readback
  assign rd_sel = cfg_index(reg_addr);
  assign cfg_rd_word = (rd_sel == DCRL_IDX_SRC) ? ctx.cfg_src :
                       (rd_sel == DCRL_IDX_DST) ? ctx.cfg_dst :
                       (rd_sel == DCRL_IDX_CNT) ? ctx.cfg_cnt : '0;

  // address select, unmapped reads as zero
  assign rd_value =
    (reg_addr == AW'(DCRL_OFS_CTRL)) ? ctrl :
    (reg_addr == AW'(DCRL_OFS_WRK_SRC)) ? ctx.wrk_src :
    (reg_addr == AW'(DCRL_OFS_WRK_DST)) ? ctx.wrk_dst :
    (reg_addr == AW'(DCRL_OFS_WRK_CNT)) ? ctx.wrk_cnt :
    (reg_addr == AW'(DCRL_OFS_STATUS)) ? status_word :
    cfg_rd_word;

  // data stand only in the cycle after the read strobe
  assign next_rdata = reg_rd ? rd_value : '0;

  // read data register
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// File: bench/dcrl_top_assertions.sv
// port-level checker for the context-reload controller
`timescale 1ns/10ps
module dcrl_top_assertions #(
  parameter int DW = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  // transfer side
  input wire logic xfer_step,
  input wire logic [DW-1:0] xfer_src,
  input wire logic [DW-1:0] xfer_dst,
  input wire logic chan_busy,
  input wire logic block_done,
  input wire logic reload_done
);
  // ----------------------------------------
  // clocking and reset
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  a_step_busy: assert property (xfer_step |-> chan_busy)
    else $error("element step while channel idle");
  a_done_after: assert property (
    block_done |-> $past(xfer_step) && !xfer_step && chan_busy)
    else $error("block end not right after last step");
  a_done_pulse: assert property (block_done |=> !block_done)
    else $error("block end pulse longer than one cycle");
  a_reload_run: assert property (
    reload_done |-> xfer_step && !$past(xfer_step))
    else $error("reload not followed by a running step");
  a_work_hold: assert property (
    !xfer_step && !$past(xfer_step) |-> $stable(xfer_src)
      && $stable(xfer_dst))
    else $error("working set moved without a step");
  a_src_count: assert property (
    xfer_step && $past(xfer_step) |-> xfer_src == $past(xfer_src) + 1'b1)
    else $error("source address not advanced by one");
  a_dst_count: assert property (
    xfer_step && $past(xfer_step) |-> xfer_dst == $past(xfer_dst) + 1'b1)
    else $error("destination address not advanced by one");
endmodule

// File: bench/dcrl_host.sv
// host processor model that programs the channel registers
`timescale 1ns/10ps
module dcrl_host (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write; control writes keep bit 10 at zero
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= (a == 4'h0) ? (d & 16'hFBFF) : d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // wait for previous context copied, then program and mark done
  task automatic reprogram(input logic [15:0] s, input logic [15:0] ctl,
                           output bit ok);
    logic [15:0] v;
    ok = 1'b0;
    repeat (50) begin
      rd(4'h0, v);
      if (v[11] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
    wr(4'h2, s);
    wr(4'h0, ctl & 16'hFDFF | 16'h0800);
  endtask
endmodule

// File: bench/dcrl_channel_context_reload_bench.sv
// self-checking bench for the context-reload controller
`timescale 1ns/10ps
module dcrl_channel_context_reload_bench;
  import dcrl_pkg::*;

  logic sys_clk;
  logic rst_b;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic xfer_step;
  logic [15:0] xfer_src;
  logic [15:0] xfer_dst;
  logic chan_busy;
  logic block_done;
  logic reload_done;
  int error_cnt = 0;
  int tests_run = 0;
  int step_cnt = 0;

  // ----------------------------------------
  // clock, reset, instances
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  dcrl_top i_dcrl_top (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_step(xfer_step),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst), .chan_busy(chan_busy),
    .block_done(block_done), .reload_done(reload_done));

  dcrl_host i_dcrl_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // counts element steps
  always @(posedge sys_clk) begin
    if (xfer_step === 1'b1) step_cnt++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                        input string n);
    logic [15:0] v;
    i_dcrl_host.rd(a, v);
    chk(n, e, v);
  endtask

  task automatic wait_for(ref logic s, input logic v, input string n);
    for (int i = 0; i < 300; i++) begin
      @(posedge sys_clk);
      if (s === v) return;
    end
    chk(n, 16'(v), 16'(s));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // stored control bits, control clear and refused working writes
  task automatic s_regs;
    rd_chk(4'h0, 16'h0000, "ctrl reset");
    rd_chk(4'hE, 16'h0000, "status reset");
    i_dcrl_host.wr(4'h0, 16'h0840);
    rd_chk(4'h0, 16'h0840, "ctrl flag");
    i_dcrl_host.wr(4'h0, 16'h0000);
    rd_chk(4'h0, 16'h0000, "ctrl clear");
    i_dcrl_host.wr(4'h8, 16'hFFFF);
    rd_chk(4'h8, 16'h0000, "wrk refused");
  endtask

  // single block with auto reload off
  task automatic s_oneshot;
    i_dcrl_host.wr(4'h2, 16'h0010);
    i_dcrl_host.wr(4'h4, 16'h0020);
    i_dcrl_host.wr(4'h6, 16'h0003);
    step_cnt = 0;
    i_dcrl_host.wr(4'h0, 16'h0080);
    wait_for(block_done, 1'b1, "block end");
    wait_for(chan_busy, 1'b0, "idle");
    chk("steps", 16'h0003, 16'(step_cnt));
    chk("wrk src", 16'h0013, xfer_src);
    chk("wrk dst", 16'h0023, xfer_dst);
    rd_chk(4'h2, 16'h0010, "cfg src");
    rd_chk(4'h0, 16'h0000, "en cleared");
  endtask

  // reload waits for the flag, then copies and clears it
  task automatic s_wait;
    bit ok;
    i_dcrl_host.wr(4'h2, 16'h0100);
    i_dcrl_host.wr(4'h6, 16'h0008);
    i_dcrl_host.wr(4'h0, 16'h0180);
    i_dcrl_host.wr(4'h2, 16'h0200);
    wait_for(block_done, 1'b1, "block end");
    chk("src kept", 16'h0108, xfer_src);
    repeat (4) @(posedge sys_clk);
    chk("no reload", 16'h0000, 16'(reload_done));
    rd_chk(4'hE, 16'h000E, "status wait");
    i_dcrl_host.reprogram(16'h0200, 16'h0180, ok);
    chk("poll", 16'h0001, 16'(ok));
    wait_for(reload_done, 1'b1, "reload");
    chk("src new", 16'h0200, xfer_src);
    rd_chk(4'h0, 16'h0180, "flag auto clear");
    i_dcrl_host.wr(4'h0, 16'h0080);
    wait_for(chan_busy, 1'b0, "stopped");
    rd_chk(4'h0, 16'h0000, "ctrl stop");
  endtask

  // immediate reload, and host flag write colliding with the clear
  task automatic s_nowait;
    i_dcrl_host.wr(4'h6, 16'h0001);
    i_dcrl_host.wr(4'h0, 16'h0380);
    wait_for(block_done, 1'b1, "block end");
    @(posedge sys_clk);
    chk("reload now", 16'h0001, 16'(reload_done));
    @(posedge sys_clk);
    // flag write lands in an end cycle; a lost clear would leave bit 11 set
    i_dcrl_host.wr(4'h0, 16'h0880);
    wait_for(chan_busy, 1'b0, "stopped");
    rd_chk(4'h0, 16'h0000, "clear wins");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_regs();
    s_oneshot();
    s_wait();
    s_nowait();
    tally_and_finish();
  end

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule

bind dcrl_top dcrl_top_assertions #(.DW(DW), .AW(AW))
  i_dcrl_top_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_step(xfer_step),
  .xfer_src(xfer_src), .xfer_dst(xfer_dst), .chan_busy(chan_busy),
  .block_done(block_done), .reload_done(reload_done));
